// ---- emf_pkg.sv ----
// Purpose: Shared constants and carriers for the executive map selector
// Assumes: 18-bit virtual addresses, 512-word pages, 20-bit absolute words
// Notes:   Octal figures of the map are kept here as sized hex constants
package emf_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_MBR = 4'h1;
   localparam logic [3:0] REG_ACB = 4'h2;
   localparam logic [3:0] REG_STAT = 4'h3;
   localparam int CTRL_UPPER_BIT = 0;
   localparam int CTRL_RESIDENT_BIT = 1;
   localparam int CTRL_SECOND_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [10:0] MBR_RESET = 11'h000;
   localparam logic [4:0] ACB_RESET = 5'h00;
   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [8:0] PAGE_CPU_START = 9'h040;
   localparam logic [8:0] PAGE_SWAP_START = 9'h080;
   localparam logic [8:0] PAGE_PROC_START = 9'h180;
   localparam logic [19:0] TBL_RESIDENT = 20'h0_0600;
   localparam logic [19:0] TBL_CPU_FIRST = 20'h0_0640;
   localparam logic [19:0] TBL_CPU_SECOND = 20'h0_07C0;
   localparam logic [19:0] TBL_SWAP = 20'h0_0680;
   localparam logic [8:0] PSB_MAP_OFFSET = 9'h180;
   localparam logic [8:0] SAVED_ACC_PAGE = 9'h1FD;
   localparam logic [17:0] LOW_FORCED_LIMIT = 18'h0_0010;
   localparam logic [17:0] SYSCALL_EA_LIMIT = 18'h0_0200;
   localparam logic [3:0] XCT_ALL_CLASSES = 4'hF;
   localparam int PC_FLAG_CALLED_BIT = 7;
   // ----------------------------------------------------------------
   // Regions and reference classes
   // ----------------------------------------------------------------
   localparam logic [1:0] RGN_RESIDENT = 2'h0;
   localparam logic [1:0] RGN_CPU = 2'h1;
   localparam logic [1:0] RGN_SWAP = 2'h2;
   localparam logic [1:0] RGN_PROCESS = 2'h3;
   localparam logic [1:0] CLS_EADDR = 2'h0;
   localparam logic [1:0] CLS_READ = 2'h1;
   localparam logic [1:0] CLS_WRITE = 2'h2;
   localparam logic [1:0] CLS_POINTER = 2'h3;

   typedef struct packed {
      logic exec_mode;
      logic user_move;
      logic acc_ref;
      logic xct_fetch;
      logic [1:0] ref_class;
      logic [3:0] xct_field;
      logic [17:0] vaddr;
   } emf_req_type;

   typedef struct packed {
      logic user_space;
      logic mapped;
      logic saved_acc;
      logic [1:0] region;
      logic [17:0] vaddr;
      logic [19:0] table_addr;
   } emf_res_type;

   function automatic logic [1:0] region_of(input logic [8:0] page);
      if (page < PAGE_CPU_START) return RGN_RESIDENT;
      if (page < PAGE_SWAP_START) return RGN_CPU;
      if (page < PAGE_PROC_START) return RGN_SWAP;
      return RGN_PROCESS;
   endfunction : region_of
endpackage : emf_pkg

// ---- emf_call_flag.sv ----
// Purpose: Called-from-executive program-counter flag
// Assumes: All strobes are one-cycle pulses on MCLK
// Notes:   A setting call outranks a clear or a restore in the same cycle
`timescale 1ns/10ps
module emf_call_flag (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Machine events
   input wire logic machine_start_reset,
   input wire logic syscall_stb,
   input wire logic syscall_exec,
   input wire logic [17:0] syscall_ea,
   // Flag save and restore
   input wire logic restore_stb,
   input wire logic restore_bit,
   output logic flag
);
   logic set_hit;
   logic flag_q;

   assign set_hit = syscall_stb && syscall_exec &&
                    (syscall_ea < emf_pkg::SYSCALL_EA_LIMIT);
   assign flag = flag_q;

   // ----------------------------------------------------------------
   // Flag register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (set_hit) begin
         flag_q <= 1'b1;
      end else if (machine_start_reset) begin
         flag_q <= 1'b0;
      end else if (restore_stb) begin
         flag_q <= restore_bit;
      end
   end
endmodule : emf_call_flag

// ---- emf_region_table.sv ----
// Purpose: Executive region decode and self-load table address
// Assumes: Combinational; caller registers the result
// Notes:   User-space references do not use this table
`timescale 1ns/10ps
module emf_region_table (
   // Page to resolve
   input wire logic [8:0] page,
   // Map configuration
   input wire logic second_cpu,
   input wire logic resident_en,
   input wire logic upper_en,
   input wire logic [10:0] mbr,
   // Result
   output logic [1:0] region,
   output logic mapped,
   output logic [19:0] table_addr
);
   logic [8:0] rel;

   always_comb begin
      region = emf_pkg::region_of(page);
      rel = 9'h000;
      mapped = 1'b0;
      table_addr = 20'h0_0000;
      case (region)
         emf_pkg::RGN_RESIDENT: begin
            mapped = resident_en;
            table_addr = emf_pkg::TBL_RESIDENT + {11'h000, page};
         end
         emf_pkg::RGN_CPU: begin
            mapped = upper_en;
            rel = page - emf_pkg::PAGE_CPU_START;
            table_addr = (second_cpu ? emf_pkg::TBL_CPU_SECOND :
                          emf_pkg::TBL_CPU_FIRST) + {11'h000, rel};
         end
         emf_pkg::RGN_SWAP: begin
            mapped = upper_en;
            rel = page - emf_pkg::PAGE_SWAP_START;
            table_addr = emf_pkg::TBL_SWAP + {11'h000, rel};
         end
         default: begin
            mapped = upper_en;
            rel = page - emf_pkg::PAGE_PROC_START;
            table_addr = {mbr, emf_pkg::PSB_MAP_OFFSET + rel};
         end
      endcase
   end
endmodule : emf_region_table

// ---- emf_exec_map.sv ----
// Purpose: Address-space selection for executive and forced user refs
// Assumes: Processor supplies mode, class and forcing per request
// Notes:   Result stands one cycle after the request strobe
`timescale 1ns/10ps
module emf_exec_map (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_B,
   // Register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   // Processor request
   input wire logic REQ_VALID,
   input wire emf_pkg::emf_req_type REQ,
   // Processor events
   input wire logic MACHINE_START_RESET,
   input wire logic EXEC_SYSCALL_STB,
   input wire logic EXEC_SYSCALL_EXEC,
   input wire logic [17:0] EXEC_SYSCALL_EA,
   input wire logic PC_FLAG_RESTORE,
   input wire logic [12:0] PC_FLAGS_IN,
   output logic CALLED_FROM_EXECUTIVE_FLAG,
   // Mapping result
   output logic RES_VALID,
   output emf_pkg::emf_res_type RES
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0] ctrl_q;
   logic [10:0] mbr_q;
   logic [4:0] acb_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic res_valid_q;
   emf_pkg::emf_res_type res_q;
   emf_pkg::emf_res_type res_d;
   logic called;
   logic forced;
   logic low_ref;
   logic [17:0] eff_vaddr;
   logic [1:0] rgn;
   logic rgn_mapped;
   logic [19:0] rgn_table;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_q <= emf_pkg::CTRL_RESET;
      end else if (REG_WR && REG_ADDR == emf_pkg::REG_CTRL) begin
         ctrl_q <= REG_WDATA[2:0];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mbr_q <= emf_pkg::MBR_RESET;
      end else if (REG_WR && REG_ADDR == emf_pkg::REG_MBR) begin
         mbr_q <= REG_WDATA[10:0];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         acb_q <= emf_pkg::ACB_RESET;
      end else if (REG_WR && REG_ADDR == emf_pkg::REG_ACB) begin
         acb_q <= REG_WDATA[4:0];
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 16'h0000;
      if (REG_RD) begin
         case (REG_ADDR)
            emf_pkg::REG_CTRL: rdata_d = {13'h0000, ctrl_q};
            emf_pkg::REG_MBR: rdata_d = {5'h00, mbr_q};
            emf_pkg::REG_ACB: rdata_d = {11'h000, acb_q};
            emf_pkg::REG_STAT: begin
               rdata_d = {10'h000, res_q.user_space, res_q.saved_acc,
                          res_q.mapped, res_q.region, called};
            end
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;

   // ----------------------------------------------------------------
   // Called-from-executive flag
   // ----------------------------------------------------------------
   emf_call_flag u_flag (
      .clk(MCLK),
      .rst_b(RST_B),
      .machine_start_reset(MACHINE_START_RESET),
      .syscall_stb(EXEC_SYSCALL_STB),
      .syscall_exec(EXEC_SYSCALL_EXEC),
      .syscall_ea(EXEC_SYSCALL_EA),
      .restore_stb(PC_FLAG_RESTORE),
      .restore_bit(PC_FLAGS_IN[emf_pkg::PC_FLAG_CALLED_BIT]),
      .flag(called)
   );

   assign CALLED_FROM_EXECUTIVE_FLAG = called;

   // ----------------------------------------------------------------
   // Forcing decision
   // ----------------------------------------------------------------
   always_comb begin
      forced = 1'b0;
      if (!REQ.acc_ref && !REQ.xct_fetch) begin
         if (REQ.user_move) begin
            forced = emf_pkg::XCT_ALL_CLASSES[REQ.ref_class];
         end else begin
            forced = REQ.xct_field[REQ.ref_class];
         end
      end
   end

   assign low_ref = REQ.vaddr < emf_pkg::LOW_FORCED_LIMIT;

   // ----------------------------------------------------------------
   // Space selection
   // ----------------------------------------------------------------
   assign eff_vaddr = (REQ.exec_mode && forced && low_ref) ?
                      {emf_pkg::SAVED_ACC_PAGE, acb_q, REQ.vaddr[3:0]} :
                      REQ.vaddr;

   always_comb begin
      res_d = '0;
      if (!REQ.exec_mode) begin
         res_d.user_space = 1'b1;
      end else if (forced && low_ref) begin
         res_d.saved_acc = 1'b1;
      end else if (forced && !called) begin
         res_d.user_space = 1'b1;
      end else begin
         res_d.user_space = 1'b0;
      end
      res_d.vaddr = eff_vaddr;
      res_d.region = res_d.user_space ? emf_pkg::RGN_RESIDENT : rgn;
      res_d.mapped = res_d.user_space ? ctrl_q[emf_pkg::CTRL_UPPER_BIT] :
                     rgn_mapped;
      res_d.table_addr = res_d.user_space ? 20'h0_0000 : rgn_table;
   end

   emf_region_table u_table (
      .page(eff_vaddr[17:9]),
      .second_cpu(ctrl_q[emf_pkg::CTRL_SECOND_BIT]),
      .resident_en(ctrl_q[emf_pkg::CTRL_RESIDENT_BIT]),
      .upper_en(ctrl_q[emf_pkg::CTRL_UPPER_BIT]),
      .mbr(mbr_q),
      .region(rgn),
      .mapped(rgn_mapped),
      .table_addr(rgn_table)
   );

   // ----------------------------------------------------------------
   // Result registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         res_valid_q <= 1'b0;
      end else begin
         res_valid_q <= REQ_VALID;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         res_q <= '0;
      end else if (REQ_VALID) begin
         res_q <= res_d;
      end
   end

   assign RES_VALID = res_valid_q;
   assign RES = res_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   region_split_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space |->
         RES.region == emf_pkg::region_of(RES.vaddr[17:9]))
      else $error("Executive region does not match address");

   fixed_swap_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space && RES.region == emf_pkg::RGN_SWAP
         |-> RES.table_addr == emf_pkg::TBL_SWAP +
             {11'h000, RES.vaddr[17:9] - emf_pkg::PAGE_SWAP_START})
      else $error("Swappable table address wrong");

   resident_gate_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && !forced &&
         REQ.vaddr[17:9] < emf_pkg::PAGE_CPU_START &&
         !ctrl_q[emf_pkg::CTRL_RESIDENT_BIT]
         |=> RES_VALID && !RES.mapped)
      else $error("Resident region mapped while disabled");

   process_block_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space && RES.region == emf_pkg::RGN_PROCESS
         |-> RES.table_addr[19:9] == $past(mbr_q) &&
             RES.table_addr[8:7] == 2'h3)
      else $error("Process table outside top of block");

   user_move_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && REQ.user_move && !REQ.acc_ref &&
         !REQ.xct_fetch && !low_ref && !called
         |=> RES.user_space && !RES.saved_acc)
      else $error("User move did not use user map");

   acc_ref_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && REQ.acc_ref
         |=> !RES.user_space && RES.vaddr == $past(REQ.vaddr))
      else $error("Accumulator reference was remapped");

   xct_fetch_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && REQ.xct_fetch
         |=> !RES.user_space && !RES.saved_acc)
      else $error("Executed instruction fetched from user");

   called_set_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      EXEC_SYSCALL_STB && EXEC_SYSCALL_EXEC &&
         EXEC_SYSCALL_EA < emf_pkg::SYSCALL_EA_LIMIT
         |=> CALLED_FROM_EXECUTIVE_FLAG)
      else $error("Executive call did not set flag");

   called_clear_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      MACHINE_START_RESET && !EXEC_SYSCALL_STB
         |=> !CALLED_FROM_EXECUTIVE_FLAG)
      else $error("Start reset left flag set");

   called_redirect_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && forced && !low_ref && called
         |=> !RES.user_space && RES.vaddr == $past(REQ.vaddr))
      else $error("Called flag failed to redirect");

   saved_acc_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && forced && low_ref
         |=> RES.saved_acc && !RES.user_space &&
             RES.vaddr[17:9] == emf_pkg::SAVED_ACC_PAGE &&
             RES.vaddr[8:4] == $past(acb_q) &&
             RES.vaddr[3:0] == $past(REQ.vaddr[3:0]))
      else $error("Saved accumulator address wrong");

   shadow_user_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && !REQ.exec_mode
         |=> RES.user_space && !RES.saved_acc &&
             RES.vaddr == $past(REQ.vaddr))
      else $error("User mode reference was redirected");

   read_once_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      !REG_RD |=> REG_RDATA == 16'h0000)
      else $error("Read data outside the answer cycle");

   fixed_cpu_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space && RES.region == emf_pkg::RGN_CPU
         |-> RES.table_addr == {11'h000, RES.vaddr[17:9] -
             emf_pkg::PAGE_CPU_START} +
             ($past(ctrl_q[emf_pkg::CTRL_SECOND_BIT]) ?
              emf_pkg::TBL_CPU_SECOND : emf_pkg::TBL_CPU_FIRST))
      else $error("Processor table address wrong");

   resident_table_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space && RES.region == emf_pkg::RGN_RESIDENT
         |-> RES.mapped == $past(ctrl_q[emf_pkg::CTRL_RESIDENT_BIT]))
      else $error("Resident mapping ignores its enable");

   field_force_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && !REQ.acc_ref && !REQ.xct_fetch &&
         REQ.xct_field[REQ.ref_class] && !low_ref && !called
         |=> RES.user_space)
      else $error("Execute field did not force user map");

   low_flag_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      REQ_VALID && REQ.exec_mode && forced && low_ref && called
         |=> RES.saved_acc)
      else $error("Called flag diverted saved accumulator");

   called_restore_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      PC_FLAG_RESTORE && !EXEC_SYSCALL_STB && !MACHINE_START_RESET
         |=> CALLED_FROM_EXECUTIVE_FLAG ==
             $past(PC_FLAGS_IN[emf_pkg::PC_FLAG_CALLED_BIT]))
      else $error("Flag restore lost bit seven");

   process_map_a: assert property (
      @(posedge MCLK) disable iff (!RST_B)
      RES_VALID && !RES.user_space && RES.region == emf_pkg::RGN_PROCESS
         |-> RES.table_addr[8:0] == RES.vaddr[17:9])
      else $error("Process page entry out of place");
endmodule : emf_exec_map

// ---- emf_cpu_model.sv ----
// Purpose: Processor-side model issuing references and flag events
// Assumes: Strobes are launched by non-blocking assignment after MCLK rises
// Notes:   Released data lines carry the inverse of their last value; strobes return low
`timescale 1ns/10ps
module emf_cpu_model (
   // Clock
   input wire logic clk,
   // Reference request
   output logic req_valid,
   output emf_pkg::emf_req_type req,
   // Machine events
   output logic start_reset,
   output logic sc_stb,
   output logic sc_exec,
   output logic [17:0] sc_ea,
   output logic restore_stb,
   output logic [12:0] pc_flags
);
   initial begin
      req_valid = 1'b0;
      req = '0;
      start_reset = 1'b0;
      sc_stb = 1'b0;
      sc_exec = 1'b0;
      sc_ea = 18'h0_0000;
      restore_stb = 1'b0;
      pc_flags = 13'h0000;
   end
   // ------------------------------------------------------------
   // Reference issue
   // ------------------------------------------------------------
   task automatic send_req(input emf_pkg::emf_req_type r);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= r;
      @(posedge clk);
      req_valid <= 1'b0;
      req <= emf_pkg::emf_req_type'(~r);
   endtask : send_req
   // ------------------------------------------------------------
   // Flag events
   // ------------------------------------------------------------
   task automatic send_events(input logic st, input logic sc,
      input logic ex, input logic [17:0] ea, input logic rs,
      input logic [12:0] fl);
      @(posedge clk);
      start_reset <= st;
      sc_stb <= sc;
      sc_exec <= ex;
      sc_ea <= ea;
      restore_stb <= rs;
      pc_flags <= fl;
      @(posedge clk);
      start_reset <= 1'b0;
      sc_stb <= 1'b0;
      restore_stb <= 1'b0;
      sc_exec <= ~ex;
      sc_ea <= ~ea;
      pc_flags <= ~fl;
   endtask : send_events
endmodule : emf_cpu_model

// ---- emf_tb.sv ----
// Purpose: Self-checking bench for the executive map selector
// Assumes: Processor model drives references and flag events
// Notes:   Expected results come from a behavioural model of the map
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("BAD %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   logic mclk;
   logic rst_b;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic req_valid;
   emf_pkg::emf_req_type req;
   emf_pkg::emf_req_type r;
   logic start_reset;
   logic sc_stb;
   logic sc_exec;
   logic [17:0] sc_ea;
   logic restore_stb;
   logic [12:0] pc_flags;
   logic called;
   logic res_valid;
   emf_pkg::emf_res_type res;
   int failures = 0;
   int comparisons = 0;
   int seed;
   logic [2:0] m_ctrl = 3'h0;
   logic [10:0] m_mbr = 11'h000;
   logic [4:0] m_acb = 5'h00;
   logic m_flag = 1'b0;
   emf_pkg::emf_res_type m_res = '0;
   logic [8:0] pages [8] = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080,
      9'h17F, 9'h180, 9'h1FF};
   logic [17:0] vas [4] = '{18'h0_0000, 18'h0_000F, 18'h0_0010, 18'h3_FFFF};

   always #5 mclk = ~mclk;

   emf_exec_map dut (
      .MCLK(mclk), .RST_B(rst_b), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .REQ_VALID(req_valid), .REQ(req),
      .MACHINE_START_RESET(start_reset), .EXEC_SYSCALL_STB(sc_stb),
      .EXEC_SYSCALL_EXEC(sc_exec), .EXEC_SYSCALL_EA(sc_ea),
      .PC_FLAG_RESTORE(restore_stb), .PC_FLAGS_IN(pc_flags),
      .CALLED_FROM_EXECUTIVE_FLAG(called), .RES_VALID(res_valid),
      .RES(res)
   );
   emf_cpu_model cpu (
      .clk(mclk), .req_valid(req_valid), .req(req),
      .start_reset(start_reset), .sc_stb(sc_stb), .sc_exec(sc_exec),
      .sc_ea(sc_ea), .restore_stb(restore_stb), .pc_flags(pc_flags)
   );
   // ------------------------------------------------------------
   // Reference model
   // ------------------------------------------------------------
   function automatic emf_pkg::emf_res_type model(
      input emf_pkg::emf_req_type q);
      emf_pkg::emf_res_type e;
      logic forced;
      logic [8:0] pg;
      e = '0;
      forced = q.exec_mode && !q.acc_ref && !q.xct_fetch &&
         (q.user_move || q.xct_field[q.ref_class]);
      e.vaddr = q.vaddr;
      if (forced && q.vaddr < 18'h0_0010) begin
         e.saved_acc = 1'b1;
         e.vaddr = {9'h1FD, m_acb, q.vaddr[3:0]};
      end else if (!q.exec_mode || (forced && !m_flag)) begin
         e.user_space = 1'b1;
         e.mapped = m_ctrl[0];
         return e;
      end
      pg = e.vaddr[17:9];
      e.mapped = m_ctrl[0];
      if (pg < 9'h040) begin
         e.mapped = m_ctrl[1];
         e.table_addr = 20'h0_0600 + 20'(pg);
      end else if (pg < 9'h080) begin
         e.region = emf_pkg::RGN_CPU;
         e.table_addr = (m_ctrl[2] ? 20'h0_07C0 : 20'h0_0640) +
            20'(pg - 9'h040);
      end else if (pg < 9'h180) begin
         e.region = emf_pkg::RGN_SWAP;
         e.table_addr = 20'h0_0680 + 20'(pg - 9'h080);
      end else begin
         e.region = emf_pkg::RGN_PROCESS;
         e.table_addr = {m_mbr, pg};
      end
      return e;
   endfunction : model

   function automatic emf_pkg::emf_req_type mk(input logic ex,
      input logic um, input logic [3:0] fld, input logic [1:0] cls,
      input logic [17:0] va);
      return '{ex, um, 1'b0, 1'b0, cls, fld, va};
   endfunction : mk
   // ------------------------------------------------------------
   // Bus and event tasks
   // ------------------------------------------------------------
   task automatic send(input emf_pkg::emf_req_type q);
      emf_pkg::emf_res_type e;
      e = model(q);
      m_res = e;
      cpu.send_req(q);
      #1;
      `CHK("res_valid", 1'b1, res_valid)
      `CHK("user_space", e.user_space, res.user_space)
      `CHK("saved_acc", e.saved_acc, res.saved_acc)
      `CHK("mapped", e.mapped, res.mapped)
      `CHK("region", e.region, res.region)
      `CHK("vaddr", e.vaddr, res.vaddr)
      if (e.mapped || e.user_space)
         `CHK("table", e.table_addr, res.table_addr)
   endtask : send

   task automatic ev(input logic st, input logic sc, input logic ex,
      input logic [17:0] ea, input logic rs, input logic [12:0] fl);
      cpu.send_events(st, sc, ex, ea, rs, fl);
      if (sc && ex && ea < 18'h0_0200) begin
         m_flag = 1'b1;
      end else if (st) begin
         m_flag = 1'b0;
      end else if (rs) begin
         m_flag = fl[7];
      end
      #1;
      `CHK("called_flag", m_flag, called)
   endtask : ev

   task automatic wr_reg(input logic [3:0] ad, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      if (ad == emf_pkg::REG_CTRL) m_ctrl = d[2:0];
      if (ad == emf_pkg::REG_MBR) m_mbr = d[10:0];
      if (ad == emf_pkg::REG_ACB) m_acb = d[4:0];
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] ad);
      logic [15:0] e;
      e = 16'h0000;
      if (ad == emf_pkg::REG_CTRL) e = {13'h0000, m_ctrl};
      if (ad == emf_pkg::REG_MBR) e = {5'h00, m_mbr};
      if (ad == emf_pkg::REG_ACB) e = {11'h000, m_acb};
      if (ad == emf_pkg::REG_STAT) e = {10'h000, m_res.user_space,
         m_res.saved_acc, m_res.mapped, m_res.region, m_flag};
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask : rd_reg

   task automatic results;
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      results();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      seed = $urandom(17);
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK("idle_valid", 1'b0, res_valid)
      `CHK("idle_flag", 1'b0, called)
      for (int i = 0; i < 16; i++) begin
         rd_reg(4'(i));
      end
      wr_reg(emf_pkg::REG_ACB, 16'hFFFF);
      wr_reg(4'h9, 16'hFFFF);
      wr_reg(emf_pkg::REG_MBR, 16'hFFFF);
      rd_reg(emf_pkg::REG_ACB);
      rd_reg(4'h9);
      rd_reg(emf_pkg::REG_MBR);
      for (int c = 0; c < 8; c++) begin
         wr_reg(emf_pkg::REG_CTRL, 16'(c));
         rd_reg(emf_pkg::REG_CTRL);
         foreach (pages[i]) begin
            send(mk(1'b1, 1'b0, 4'h0, 2'h0, {pages[i], 9'h0AB}));
         end
      end
      wr_reg(emf_pkg::REG_CTRL, 16'h0003);
      wr_reg(emf_pkg::REG_MBR, 16'h05A5);
      wr_reg(emf_pkg::REG_ACB, 16'h0015);
      foreach (vas[i]) begin
         send(mk(1'b1, 1'b0, 4'h0, 2'h1, vas[i]));
         send(mk(1'b1, 1'b1, 4'h0, 2'h1, vas[i]));
         send(mk(1'b0, 1'b1, 4'h0, 2'h1, vas[i]));
      end
      for (int c = 0; c < 4; c++) begin
         for (int b = 0; b < 4; b++) begin
            send(mk(1'b1, 1'b0, 4'(1 << b), 2'(c), 18'h0_2000));
         end
      end
      r = mk(1'b1, 1'b0, 4'hF, 2'h2, 18'h0_2000);
      r.xct_fetch = 1'b1;
      send(r);
      r = mk(1'b1, 1'b1, 4'hF, 2'h1, 18'h0_0004);
      r.acc_ref = 1'b1;
      send(r);
      send(mk(1'b1, 1'b0, 4'hF, 2'h3, 18'h0_0003));
      ev(1'b0, 1'b1, 1'b1, 18'h0_01FF, 1'b0, 13'h0000);
      send(mk(1'b1, 1'b1, 4'h0, 2'h1, 18'h0_1000));
      send(mk(1'b1, 1'b1, 4'h0, 2'h1, 18'h0_0005));
      ev(1'b1, 1'b0, 1'b0, 18'h0_0000, 1'b0, 13'h0000);
      ev(1'b0, 1'b1, 1'b1, 18'h0_0200, 1'b0, 13'h0000);
      ev(1'b0, 1'b1, 1'b0, 18'h0_0010, 1'b0, 13'h0000);
      ev(1'b0, 1'b0, 1'b0, 18'h0_0000, 1'b1, 13'h0080);
      ev(1'b1, 1'b1, 1'b1, 18'h0_0000, 1'b0, 13'h0000);
      ev(1'b0, 1'b0, 1'b1, 18'h0_0000, 1'b1, 13'h1F7F);
      for (int i = 0; i < 400; i++) begin
         case ($urandom % 8)
            0: ev(1'($urandom), 1'($urandom), 1'($urandom),
               18'($urandom % 1024), 1'($urandom), 13'($urandom));
            1: wr_reg(4'($urandom), 16'($urandom));
            2: rd_reg(4'($urandom));
            default: begin
               r = emf_pkg::emf_req_type'(28'($urandom));
               if ($urandom % 3 == 0) r.vaddr = 18'($urandom % 32);
               send(r);
            end
         endcase
      end
      results();
   end
endmodule : tb
